// >>> shared/bridge_pkg.sv
// package: bus cycle types, timing counts and carrier structs for the bridge
package bridge_pkg;
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_HI_LSB = 8;
	// read capture goes through a two-flop synchroniser, so a T-state
	// must span at least three sys_clk cycles
	localparam int T_STATE_NS = 12;
	localparam int CLK_NS = 4;
	// one bus T-state in sys_clk cycles, at least one
	localparam int T_CYCLES = (T_STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] ADDR_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_STROBE = 3'b010,
		ST_END = 3'b011,
		ST_HOLD = 3'b100
	} cycle_state_t;

	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_IRQ_ACK = 2'b10
	} bus_op_t;

	typedef struct packed {
		bus_op_t op;
		logic io_space;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic mem_space_read_n;
		logic mem_space_store_n;
		logic io_space_read_n;
		logic io_space_store_n;
	} space_strobes_t;
endpackage

// >>> hw/muxed_bus_demux_bridge.sv
// muxed bus cycle generator with address latch and space strobe decoder
//
// Behaviour
// - each cycle opens with full 16-bit address, high byte dedicated, low shared
// - latch strobe rises on the same edge as the address so the low byte is captured
// - on reads shared lines float once the read strobe is active
// - upper address changes only at the start of each cycle and holds to its end
// - writes follow read timing; data driven after latch strobe falls
// - space-select shows io or memory for the current transfer
// - read, write and interrupt acknowledge strobes share identical timing
// - strobe and hold timing unchanged when heading into bus hold
// - write data stable before write strobe trailing edge; capture there
// - eight-bit latch gives downstream a separate 16-bit address
// - decode read, write, space-select into four space strobes
`timescale 1ns/1ps
module muxed_bus_demux_bridge
	import bridge_pkg::*;
#(
	parameter int T_STATE_CYCLES = T_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire bus_req_t req,
	input wire logic hold_request,
	output logic hold_grant,
	output logic rdata_valid,
	output logic [7:0] rdata,
	output logic [7:0] upper_address,
	output logic [7:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe,
	input wire logic [7:0] muxed_addr_data_in,
	output logic addr_latch_strobe,
	output logic read_n,
	output logic write_n,
	output logic irq_acknowledge_n,
	output logic io_select,
	output logic [15:0] demux_address,
	output space_strobes_t space_strobes
);
	// the synchronised read data needs three cycles of strobe to settle
	if (T_STATE_CYCLES < 3) begin : g_bad_timing
		$error("T_STATE_CYCLES must be at least three");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [7:0] ad_meta, ad_sync;
	logic hold_meta, hold_sync;
	always_ff @(posedge sys_clk) begin
		ad_meta <= muxed_addr_data_in;
		ad_sync <= ad_meta;
		hold_meta <= hold_request;
		hold_sync <= hold_meta;
	end

	// ------------------------------------------------------------
	// cycle sequencer
	// ------------------------------------------------------------
	cycle_state_t state, next_state;
	logic [15:0] tcnt;
	bus_req_t cur;
	wire t_done = (tcnt == 16'(T_STATE_CYCLES - 1));
	wire start = (state == ST_IDLE) && req_valid && !hold_sync;
	assign req_ready = (state == ST_IDLE) && !hold_sync;

	always_comb begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (hold_sync)
				next_state = ST_HOLD;
			else if (req_valid)
				next_state = ST_ADDR;
		end
		ST_ADDR: begin
			if (t_done)
				next_state = ST_STROBE;
		end
		ST_STROBE: begin
			if (t_done)
				next_state = ST_END;
		end
		// hold is only entered from idle so strobe timing never shortens
		ST_END: begin
			if (t_done)
				next_state = ST_IDLE;
		end
		ST_HOLD: begin
			if (!hold_sync)
				next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
	end

	wire state_change = (next_state != state);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			tcnt <= 16'h0000;
			cur <= '0;
		end else begin
			state <= next_state;
			tcnt <= state_change ? 16'h0000 : tcnt + 16'h0001;
			if (start)
				cur <= req;
		end
	end

	// ------------------------------------------------------------
	// processor-side pins
	// ------------------------------------------------------------
	wire in_cycle = (state == ST_ADDR) || (state == ST_STROBE) ||
		(state == ST_END);
	wire is_read = (cur.op == OP_READ);
	wire is_write = (cur.op == OP_WRITE);
	wire is_ack = (cur.op == OP_IRQ_ACK);
	wire strobing = (state == ST_STROBE);
	wire next_ale = (next_state == ST_ADDR);
	wire next_strobe = (next_state == ST_STROBE);
	// data phase covers strobe and end states; address phase the first
	wire drive_addr = (next_state == ST_ADDR);
	wire drive_wdata = (next_state == ST_STROBE || next_state == ST_END)
		&& is_write;
	// low address stands through the whole latch strobe, then data
	wire [7:0] next_ad = start ? req.addr[7:0] :
		drive_addr ? cur.addr[7:0] : cur.wdata;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			upper_address <= BYTE_ZERO;
			muxed_addr_data_out <= BYTE_ZERO;
			muxed_addr_data_oe <= 1'b0;
			addr_latch_strobe <= 1'b0;
			read_n <= 1'b1;
			write_n <= 1'b1;
			irq_acknowledge_n <= 1'b1;
			io_select <= 1'b0;
			hold_grant <= 1'b0;
		end else begin
			if (start) begin
				upper_address <= req.addr[15:ADDR_HI_LSB];
				io_select <= req.io_space;
			end
			muxed_addr_data_out <= next_ad;
			// reads float the shared lines while strobed
			muxed_addr_data_oe <= drive_addr || drive_wdata;
			addr_latch_strobe <= next_ale;
			// one timing for every strobe type
			read_n <= !(next_strobe && is_read);
			write_n <= !(next_strobe && is_write);
			irq_acknowledge_n <= !(next_strobe && is_ack);
			hold_grant <= (next_state == ST_HOLD);
		end
	end

	// ------------------------------------------------------------
	// read data capture at trailing edge of read strobe
	// ------------------------------------------------------------
	wire rd_trailing = strobing && t_done && is_read;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata <= BYTE_ZERO;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= rd_trailing;
			if (rd_trailing)
				rdata <= ad_sync;
		end
	end

	// ------------------------------------------------------------
	// demultiplexing latch and strobe decoder
	// ------------------------------------------------------------
	logic [7:0] low_held;
	always_ff @(posedge sys_clk) begin
		if (rst)
			low_held <= BYTE_ZERO;
		else if (addr_latch_strobe)
			low_held <= muxed_addr_data_out;
	end
	// transparent while strobe high, held value otherwise
	wire [7:0] low_addr = addr_latch_strobe ? muxed_addr_data_out :
		low_held;
	assign demux_address = {upper_address, low_addr};

	assign space_strobes.mem_space_read_n = read_n | io_select;
	assign space_strobes.mem_space_store_n = write_n | io_select;
	assign space_strobes.io_space_read_n = read_n | !io_select;
	assign space_strobes.io_space_store_n = write_n | !io_select;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_ale_then_strobe;
		addr_latch_strobe ##T_STATE_CYCLES !addr_latch_strobe;
	endsequence

	a_addr_before_ale: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(addr_latch_strobe) |-> muxed_addr_data_oe &&
		muxed_addr_data_out == demux_address[7:0])
		else $error("address not presented with latch strobe");
	a_ale_pulse_len: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(addr_latch_strobe) |-> s_ale_then_strobe)
		else $error("latch strobe width wrong");
	a_read_float: assert property (@(posedge sys_clk) disable iff (rst)
		!read_n |-> !muxed_addr_data_oe)
		else $error("shared lines driven during read strobe");
	a_write_data_on: assert property (@(posedge sys_clk) disable iff (rst)
		!write_n |-> muxed_addr_data_oe &&
		muxed_addr_data_out == cur.wdata)
		else $error("write data missing during write strobe");
	a_one_strobe: assert property (@(posedge sys_clk) disable iff (rst)
		$onehot0({!read_n, !write_n, !irq_acknowledge_n}))
		else $error("more than one strobe active");
	a_strobe_width: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(read_n & write_n & irq_acknowledge_n) |->
		!(read_n & write_n & irq_acknowledge_n) [*1] ##(T_STATE_CYCLES)
		(read_n & write_n & irq_acknowledge_n))
		else $error("strobe width changed");
	a_hold_no_strobe: assert property (@(posedge sys_clk) disable iff (rst)
		hold_grant |-> read_n && write_n && !muxed_addr_data_oe)
		else $error("bus active while held");
	a_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
		!addr_latch_strobe && !$rose(state == ST_ADDR) && !$past(addr_latch_strobe)
		|-> $stable(demux_address[7:0]))
		else $error("latched low address moved");
	a_space_decode: assert property (@(posedge sys_clk) disable iff (rst)
		!space_strobes.io_space_read_n |-> !read_n && io_select)
		else $error("io read strobe without source");
	a_io_sel_stable: assert property (@(posedge sys_clk) disable iff (rst)
		in_cycle && !start && $past(in_cycle) |-> $stable(io_select))
		else $error("space select moved mid cycle");
endmodule

// >>> tb/bus_device_model.sv
// memory and io device model on the demultiplexed side of the bridge
`timescale 1ns/1ps
module bus_device_model
	import bridge_pkg::*;
(
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic [15:0] demux_address,
	input wire space_strobes_t space_strobes,
	input wire logic [7:0] muxed_addr_data_out,
	output logic [7:0] data_in,
	output logic wr_seen,
	output logic [24:0] wr_info
);
	logic rd_act, wr_act, wr_d, rd_d, rd_io, drive;
	logic [7:0] junk;
	assign rd_io = !space_strobes.io_space_read_n;
	assign rd_act = !space_strobes.mem_space_read_n || rd_io;
	assign wr_act = !space_strobes.mem_space_store_n
		|| !space_strobes.io_space_store_n;
	// slow device answers one cycle after its strobe
	assign drive = rd_act && (!slow || rd_d);
	// released lines show a changing pattern, never the last byte
	assign data_in = drive ? (demux_address[7:0] ^ demux_address[15:8]
		^ (rd_io ? 8'hC3 : 8'h00)) : junk;
	initial begin
		junk = 8'hA5;
		rd_d = 1'b0;
		wr_d = 1'b0;
		wr_seen = 1'b0;
		wr_info = '0;
	end
	always @(posedge sys_clk) begin
		junk <= ~junk;
		rd_d <= rd_act;
		wr_d <= wr_act;
		wr_seen <= wr_d && !wr_act;
		// last value before the trailing edge is the one kept
		if (wr_act) begin
			wr_info <= {!space_strobes.io_space_store_n, demux_address,
				muxed_addr_data_out};
		end
	end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the bridge with a device model behind it
`timescale 1ns/1ps
module tb_top
	import bridge_pkg::*;
;
	logic sys_clk, rst, req_valid, hold_request, slow, ack_phase;
	bus_req_t req;
	logic req_ready, hold_grant, rdata_valid, oe, ale, rd_n, wr_n, ack_n;
	logic io_sel, wr_seen;
	logic [7:0] rdata, upa, mout, min;
	logic [15:0] daddr;
	logic [24:0] wr_info;
	space_strobes_t ss;
	logic [24:0] rd_q[$], wr_q[$];
	int error_cnt = 0;
	int num_checks = 0;

	muxed_bus_demux_bridge #(.T_STATE_CYCLES(4)) i_dut (.sys_clk(sys_clk),
		.rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.hold_request(hold_request), .hold_grant(hold_grant),
		.rdata_valid(rdata_valid), .rdata(rdata), .upper_address(upa),
		.muxed_addr_data_out(mout), .muxed_addr_data_oe(oe),
		.muxed_addr_data_in(min), .addr_latch_strobe(ale), .read_n(rd_n),
		.write_n(wr_n), .irq_acknowledge_n(ack_n), .io_select(io_sel),
		.demux_address(daddr), .space_strobes(ss));
	bus_device_model i_dev (.sys_clk(sys_clk), .slow(slow),
		.demux_address(daddr), .space_strobes(ss),
		.muxed_addr_data_out(mout), .data_in(min), .wr_seen(wr_seen),
		.wr_info(wr_info));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [24:0] e, g);
		num_checks++;
		if (e !== g) begin
			$display("wrong value %s exp %h got %h", what, e, g);
			error_cnt++;
		end
	endtask

	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		while (s !== v) begin
			@(negedge sys_clk);
			if (++n > 300) begin
				error_cnt++;
				conclude();
			end
		end
	endtask

	task automatic issue(input bus_op_t op, input logic io,
		input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req_valid = 1'b1;
		req = '{op, io, a, d};
		if (op == OP_READ) rd_q.push_back({17'h0, a[7:0] ^ a[15:8]
			^ (io ? 8'hC3 : 8'h00)});
		if (op == OP_WRITE) wr_q.push_back({io, a, d});
		wait_for(req_ready, 1'b1);
		@(negedge sys_clk);
		req_valid = 1'b0;
	endtask

	// results are checked in arrival order against the noted ones
	always @(negedge sys_clk) begin
		if (rdata_valid === 1'b1 && !ack_phase) begin
			cmp("rdata", rd_q.size() ? rd_q.pop_front() : 'x,
				{17'h0, rdata});
		end
		if (wr_seen) begin
			cmp("write", wr_q.size() ? wr_q.pop_front() : 'x,
				wr_info);
		end
	end

	initial begin
		logic [16:0] r;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		hold_request = 1'b0;
		slow = 1'b0;
		ack_phase = 1'b0;
		void'($urandom(32'h649E));
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		for (int i = 0; i < 40; i++) begin
			r = $urandom;
			slow = r[16];
			issue(bus_op_t'(r[0]), r[1], 16'($urandom), 8'($urandom));
		end
		$display("test random transfers done");
		for (int i = 0; i < 8; i++) begin
			issue(bus_op_t'(i[0]), i[1], i[2] ? 16'hFFFF : 16'h0000, 8'hFF);
		end
		$display("test boundary addresses done");
		wait_for(oe, 1'b0);
		ack_phase = 1'b1;
		issue(OP_IRQ_ACK, 1'b0, 16'h1234, 8'h00);
		wait_for(ack_n, 1'b0);
		cmp("strobes", 25'h0F, {21'h0, ss});
		wait_for(req_ready, 1'b1);
		ack_phase = 1'b0;
		$display("test interrupt acknowledge done");
		// hold asked for mid-cycle: the write must finish with full timing
		issue(OP_WRITE, 1'b1, 16'h5AA5, 8'hC3);
		hold_request = 1'b1;
		wait_for(hold_grant, 1'b1);
		cmp("ready", 25'h0, {24'h0, req_ready});
		hold_request = 1'b0;
		wait_for(hold_grant, 1'b0);
		issue(OP_READ, 1'b1, 16'h80F1, 8'h00);
		issue(OP_WRITE, 1'b0, 16'h7E0C, 8'h3C);
		$display("test hold done");
		repeat (40) @(negedge sys_clk);
		cmp("pending", 25'h0, 25'(rd_q.size() + wr_q.size()));
		conclude();
	end
endmodule
